// [design/nct_command_poll.sv]
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module nct_command_poll #(
  parameter int ADDR_WIDTH  = 8,
  parameter int PTR_WIDTH   = 64,
  parameter int RESET_TICKS = nct_pkg::SOFT_RESET_CYCLES
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic [ADDR_WIDTH-1:0] regAddr,
  input  wire logic [15:0]           regWrData,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output var  logic [15:0]           regRdData,
  input  wire logic [PTR_WIDTH-1:0]  normalTxDescBase,
  input  wire logic [PTR_WIDTH-1:0]  highTxDescBase,
  input  wire logic [PTR_WIDTH-1:0]  rxDescBase,
  input  wire logic                  highQueueEmpty,
  input  wire logic                  normalQueueEmpty,
  output var  logic                  rxPathEnable,
  output var  logic                  txPathEnable,
  output var  logic                  fifoReinit,
  output var  logic                  highPrioPending,
  output var  logic                  normalPrioPending,
  output var  logic [PTR_WIDTH-1:0]  normalTxPtr,
  output var  logic [PTR_WIDTH-1:0]  highTxPtr,
  output var  logic [PTR_WIDTH-1:0]  rxPtr,
  output var  logic                  irqOut
);
  import nct_pkg::*;

  if (ADDR_WIDTH < 8 || RESET_TICKS < 1 ||
      RESET_TICKS > 65535 || PTR_WIDTH < 1) begin : gen_bad_param
    $error("nct_command_poll: bad parameter");
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic wrCmd;
  logic wrPoll;
  logic wrMask;
  logic rdStatus;
  assign wrCmd    = regWrite && (regAddr == ADDR_WIDTH'(OFS_COMMAND_CONTROL));
  assign wrPoll   = regWrite && (regAddr == ADDR_WIDTH'(OFS_TRANSMIT_POLL));
  assign wrMask   = regWrite && (regAddr == ADDR_WIDTH'(OFS_IRQ_MASK));
  assign rdStatus = regRead && (regAddr == ADDR_WIDTH'(OFS_IRQ_STATUS));

  // ----------------------------------------
  // soft reset sequencer
  // ----------------------------------------
  nct_reset_state_t srState_q;
  logic [15:0]      srCount_q;
  logic             srActive;
  assign srActive = (srState_q != SR_IDLE);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      srState_q <= SR_IDLE;
      srCount_q <= 16'h0000;
    end else begin
      unique case (srState_q)
        SR_IDLE: begin
          if (wrCmd && regWrData[BIT_SOFT_RESET]) begin
            srState_q <= SR_BUSY;
            srCount_q <= 16'(RESET_TICKS - 1);
          end
        end
        SR_BUSY: begin
          if (srCount_q == 16'h0000) begin
            srState_q <= SR_DONE;
          end else begin
            srCount_q <= srCount_q - 16'h0001;
          end
        end
        SR_DONE: begin
          srState_q <= SR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fifoReinit <= 1'b0;
    end else begin
      fifoReinit <= srActive || (wrCmd && regWrData[BIT_SOFT_RESET]);
    end
  end

  // ----------------------------------------
  // path enables
  // ----------------------------------------
  logic rxEn_q;
  logic txEn_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rxEn_q <= RST_COMMAND_CONTROL[BIT_RX_PATH_ENABLE];
      txEn_q <= RST_COMMAND_CONTROL[BIT_TX_PATH_ENABLE];
    end else if (srActive) begin
      rxEn_q <= 1'b0;
      txEn_q <= 1'b0;
    end else if (wrCmd && !regWrData[BIT_SOFT_RESET]) begin
      rxEn_q <= regWrData[BIT_RX_PATH_ENABLE];
      txEn_q <= regWrData[BIT_TX_PATH_ENABLE];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rxPathEnable <= 1'b0;
      txPathEnable <= 1'b0;
    end else begin
      rxPathEnable <= rxEn_q && !srActive && !(wrCmd && regWrData[BIT_SOFT_RESET]);
      txPathEnable <= txEn_q && !srActive && !(wrCmd && regWrData[BIT_SOFT_RESET]);
    end
  end

  // ----------------------------------------
  // buffer pointers
  // ----------------------------------------
  // reload pointers during reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n || srActive) begin
      normalTxPtr <= normalTxDescBase;
      highTxPtr   <= highTxDescBase;
      rxPtr       <= rxDescBase;
    end
  end
  // no station, multicast or config state here

  // ----------------------------------------
  // transmit poll
  // ----------------------------------------
  logic highPoll_q;
  logic normalPoll_q;
  logic forcedIrq_q;

  // high poll set by writing one
  always_ff @(posedge clk_sys) begin
    if (!reset_n || srActive) begin
      highPoll_q <= RST_TRANSMIT_POLL[BIT_HIGH_PRIO_POLL];
    end else if (wrPoll && regWrData[BIT_HIGH_PRIO_POLL]) begin
      highPoll_q <= 1'b1;
    end else if (highPoll_q && highQueueEmpty) begin
      highPoll_q <= 1'b0;
    end
  end

  // normal poll set by writing one
  always_ff @(posedge clk_sys) begin
    if (!reset_n || srActive) begin
      normalPoll_q <= RST_TRANSMIT_POLL[BIT_NORMAL_PRIO_POLL];
    end else if (wrPoll && regWrData[BIT_NORMAL_PRIO_POLL]) begin
      normalPoll_q <= 1'b1;
    end else if (normalPoll_q && normalQueueEmpty) begin
      normalPoll_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      highPrioPending   <= 1'b0;
      normalPrioPending <= 1'b0;
    end else begin
      highPrioPending   <= highPoll_q && txEn_q && !srActive;
      normalPrioPending <= normalPoll_q && txEn_q && !srActive;
    end
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  logic [15:0] irqStatus_q;
  logic [15:0] irqMask_q;
  logic        forceSet;
  assign forceSet = wrPoll && regWrData[BIT_FORCED_SOFT_IRQ];

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irqStatus_q <= RST_IRQ_STATUS;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (i == BIT_SOFT_IRQ_STATUS && forceSet) begin
          irqStatus_q[i] <= 1'b1;
        end else if (rdStatus) begin
          irqStatus_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irqMask_q <= RST_IRQ_MASK;
    end else if (wrMask) begin
      irqMask_q <= regWrData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      forcedIrq_q <= RST_TRANSMIT_POLL[BIT_FORCED_SOFT_IRQ];
    end else if (forceSet) begin
      forcedIrq_q <= 1'b1;
    end else if (!irqStatus_q[BIT_SOFT_IRQ_STATUS]) begin
      forcedIrq_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(irqStatus_q & irqMask_q);
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [7:0] cmdView;
  logic [7:0] pollView;
  always_comb begin
    cmdView = 8'h00;
    cmdView[BIT_SOFT_RESET]     = srActive;
    cmdView[BIT_RX_PATH_ENABLE] = rxEn_q;
    cmdView[BIT_TX_PATH_ENABLE] = txEn_q;
    pollView = 8'h00;
    pollView[BIT_HIGH_PRIO_POLL]   = highPoll_q;
    pollView[BIT_NORMAL_PRIO_POLL] = normalPoll_q;
    pollView[BIT_FORCED_SOFT_IRQ]  = forcedIrq_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      regRdData <= 16'h0000;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_WIDTH'(OFS_COMMAND_CONTROL): regRdData <= {8'h00, cmdView};
        ADDR_WIDTH'(OFS_TRANSMIT_POLL):   regRdData <= {8'h00, pollView};
        ADDR_WIDTH'(OFS_IRQ_STATUS):      regRdData <= irqStatus_q;
        ADDR_WIDTH'(OFS_IRQ_MASK):        regRdData <= irqMask_q;
        default:                          regRdData <= 16'h0000;
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  localparam int SR_SPAN = RESET_TICKS + 1;

  chk_reset_self_clear: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (srState_q == SR_IDLE && wrCmd && regWrData[BIT_SOFT_RESET])
      |=> srActive [*2] ##[0:SR_SPAN] !srActive)
    else $error("soft reset did not self clear");

  chk_reset_paths_off: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    srActive |=> !rxPathEnable && !txPathEnable && fifoReinit)
    else $error("paths active during soft reset");

  chk_reset_ptr_load: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (srActive && $stable(rxDescBase) && $stable(highTxDescBase))
      |=> rxPtr == $past(rxDescBase) && highTxPtr == $past(highTxDescBase))
    else $error("pointer not reloaded");

  chk_enable_follow: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (wrCmd && !srActive && !regWrData[BIT_SOFT_RESET])
      |=> ##1 rxPathEnable == $past(regWrData[BIT_RX_PATH_ENABLE], 2))
    else $error("receive enable wrong");

  chk_high_poll_set: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (wrPoll && regWrData[BIT_HIGH_PRIO_POLL] && !srActive) |=> highPoll_q)
    else $error("high poll not set");

  chk_high_poll_hold: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (highPoll_q && !highQueueEmpty && !srActive) |=> highPoll_q)
    else $error("high poll dropped early");

  chk_normal_poll_hold: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (normalPoll_q && !normalQueueEmpty && !srActive) |=> normalPoll_q)
    else $error("normal poll dropped early");

  chk_zero_no_effect: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (wrPoll && !regWrData[BIT_NORMAL_PRIO_POLL] && !normalPoll_q) |=> !normalPoll_q)
    else $error("zero write set normal poll");

  chk_force_sets_flag: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    forceSet |=> irqStatus_q[BIT_SOFT_IRQ_STATUS] && forcedIrq_q)
    else $error("forced irq did not set status");

  chk_force_clear: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (forcedIrq_q && !irqStatus_q[BIT_SOFT_IRQ_STATUS] && !forceSet) |=> !forcedIrq_q)
    else $error("forced bit not cleared");

  cov_soft_reset: cover property (
    @(posedge clk_sys) disable iff (!reset_n) srState_q == SR_DONE);
  cov_high_drain: cover property (
    @(posedge clk_sys) disable iff (!reset_n) highPoll_q ##1 !highPoll_q);
  cov_force_irq: cover property (
    @(posedge clk_sys) disable iff (!reset_n) forceSet ##[1:4] irqOut);

endmodule : nct_command_poll

`default_nettype wire

// [pkg/nct_pkg.sv]
package nct_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_COMMAND_CONTROL = 8'h37;
  localparam logic [7:0] OFS_TRANSMIT_POLL   = 8'h38;
  localparam logic [7:0] OFS_IRQ_STATUS      = 8'h3e;
  localparam logic [7:0] OFS_IRQ_MASK        = 8'h3c;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_SOFT_RESET       = 4;
  localparam int BIT_RX_PATH_ENABLE   = 3;
  localparam int BIT_TX_PATH_ENABLE   = 2;
  localparam int BIT_HIGH_PRIO_POLL   = 7;
  localparam int BIT_NORMAL_PRIO_POLL = 6;
  localparam int BIT_FORCED_SOFT_IRQ  = 0;
  localparam int BIT_SOFT_IRQ_STATUS  = 8;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0]  RST_COMMAND_CONTROL = 8'h00;
  localparam logic [7:0]  RST_TRANSMIT_POLL   = 8'h00;
  localparam logic [15:0] RST_IRQ_STATUS      = 16'h0000;
  localparam logic [15:0] RST_IRQ_MASK        = 16'h0000;
  localparam int          SOFT_RESET_CYCLES   = 16;

  typedef enum logic [1:0] {
    SR_IDLE,
    SR_BUSY,
    SR_DONE
  } nct_reset_state_t;

endpackage : nct_pkg

// [verif/nct_command_poll_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module nct_command_poll_tb;
  import nct_pkg::*;

  localparam int TICKS = 8;

  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [15:0] regRdData;
  logic [63:0] normalTxDescBase = 64'h0;
  logic [63:0] highTxDescBase = 64'h0;
  logic [63:0] rxDescBase = 64'h0;
  logic        highQueueEmpty = 1'b0;
  logic        normalQueueEmpty = 1'b0;
  logic        rxPathEnable;
  logic        txPathEnable;
  logic        fifoReinit;
  logic        highPrioPending;
  logic        normalPrioPending;
  logic [63:0] normalTxPtr;
  logic [63:0] highTxPtr;
  logic [63:0] rxPtr;
  logic        irqOut;
  int          errTotal = 0;
  int          checksDone = 0;
  logic [31:0] seed = 32'h0000_5285;
  logic [15:0] rd;
  logic [7:0]  cmd;

  nct_command_poll #(.ADDR_WIDTH(8), .PTR_WIDTH(64), .RESET_TICKS(TICKS)) nct_command_poll_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .normalTxDescBase(normalTxDescBase), .highTxDescBase(highTxDescBase),
    .rxDescBase(rxDescBase), .highQueueEmpty(highQueueEmpty),
    .normalQueueEmpty(normalQueueEmpty), .rxPathEnable(rxPathEnable),
    .txPathEnable(txPathEnable), .fifoReinit(fifoReinit),
    .highPrioPending(highPrioPending), .normalPrioPending(normalPrioPending),
    .normalTxPtr(normalTxPtr), .highTxPtr(highTxPtr), .rxPtr(rxPtr), .irqOut(irqOut)
  );

  always #20 clk_sys = ~clk_sys;

  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand

  // enables expected back from a command write
  function automatic logic [15:0] cmd_expect(logic [7:0] d);
    return {8'h00, d & 8'h0c};
  endfunction : cmd_expect

  task automatic check(logic [63:0] got, logic [63:0] exp, string what);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr_reg(logic [7:0] a, logic [15:0] d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge clk_sys);
    regWrite  <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd_reg

  task automatic settle(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic wrap_up();
    if (errTotal == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #(40 * 5000);
    errTotal++;
    wrap_up();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    normalTxDescBase <= {next_rand(), next_rand()};
    highTxDescBase   <= {next_rand(), next_rand()};
    rxDescBase       <= {next_rand(), next_rand()};
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    settle(1);
    check(normalTxPtr, normalTxDescBase, "normal ptr");
    rd_reg(OFS_COMMAND_CONTROL, rd);
    check(rd, 16'h0000, "command reset");
    rd_reg(8'h40, rd);
    check(rd, 16'h0000, "unmapped read");
    // random enable patterns, corners forced first
    for (int i = 0; i < 8; i++) begin
      cmd = (i == 0) ? 8'hef : (i == 1) ? 8'h0c : (8'(next_rand()) & 8'hef);
      wr_reg(OFS_COMMAND_CONTROL, {8'h00, cmd});
      settle(2);
      check(rxPathEnable, cmd[3], "rx enable");
      check(txPathEnable, cmd[2], "tx enable");
      rd_reg(OFS_COMMAND_CONTROL, rd);
      check(rd, cmd_expect(cmd), "command readback");
    end
    wr_reg(OFS_COMMAND_CONTROL, 16'h000c);
    // high then normal polling, zero writes ignored
    for (int p = 0; p < 2; p++) begin
      wr_reg(OFS_TRANSMIT_POLL, (p == 0) ? 16'h0080 : 16'h0040);
      settle(2);
      check(highPrioPending, p == 0, "high pending");
      check(normalPrioPending, p == 1, "normal pending");
      wr_reg(OFS_TRANSMIT_POLL, 16'h0000);
      settle(3);
      check({highPrioPending, normalPrioPending}, (p == 0) ? 2'b10 : 2'b01, "zero poll");
      if (p == 0) highQueueEmpty <= 1'b1;
      else normalQueueEmpty <= 1'b1;
      settle(3);
      check({highPrioPending, normalPrioPending}, 2'b00, "poll self clear");
      highQueueEmpty   <= 1'b0;
      normalQueueEmpty <= 1'b0;
    end
    // forced interrupt, masked then unmasked
    wr_reg(OFS_TRANSMIT_POLL, 16'h0001);
    settle(3);
    check(irqOut, 1'b0, "masked irq");
    rd_reg(OFS_TRANSMIT_POLL, rd);
    check(rd, 16'h0001, "forced bit set");
    wr_reg(OFS_IRQ_MASK, 16'h0100);
    settle(3);
    check(irqOut, 1'b1, "forced irq");
    rd_reg(OFS_IRQ_STATUS, rd);
    check(rd, 16'h0100, "soft irq status");
    settle(3);
    check(irqOut, 1'b0, "irq after clear");
    rd_reg(OFS_IRQ_STATUS, rd);
    check(rd, 16'h0000, "status cleared");
    rd_reg(OFS_TRANSMIT_POLL, rd);
    check(rd, 16'h0000, "forced bit cleared");
    wr_reg(OFS_TRANSMIT_POLL, 16'h0000);
    settle(3);
    check(irqOut, 1'b0, "zero force");
    // soft reset with traffic pending and moved bases
    wr_reg(OFS_TRANSMIT_POLL, 16'h0080);
    normalTxDescBase <= {next_rand(), next_rand()};
    highTxDescBase   <= {next_rand(), next_rand()};
    rxDescBase       <= {next_rand(), next_rand()};
    wr_reg(OFS_COMMAND_CONTROL, 16'h001c);
    settle(2);
    check(fifoReinit, 1'b1, "fifo reinit");
    check({rxPathEnable, txPathEnable}, 2'b00, "paths off");
    check(normalTxPtr, normalTxDescBase, "normal ptr");
    check(highTxPtr, highTxDescBase, "high ptr");
    check(rxPtr, rxDescBase, "rx ptr");
    rd_reg(OFS_COMMAND_CONTROL, rd);
    check(rd[4], 1'b1, "reset busy");
    settle(TICKS + 4);
    rd_reg(OFS_COMMAND_CONTROL, rd);
    check(rd, 16'h0000, "reset self clear");
    check(fifoReinit, 1'b0, "fifo reinit end");
    rd_reg(OFS_IRQ_MASK, rd);
    check(rd, 16'h0100, "mask kept");
    wrap_up();
  end

endmodule : nct_command_poll_tb

`default_nettype wire
